// ===== tb/test_usc_status_control.sv
`timescale 1ns/100ps
`include "usc_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module test_usc_status_control;
   logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, err, tokenDone, tokenIsIn, tokenOdd, setupSeen, tokenValid, sofSeen, busResetSeen;
   logic [3:0]  tokenEndpoint;
   logic [6:0]  tokenAddress;
   logic [10:0] sofFrame;
   logic        addressMatch, moduleEnable, transactionSuspend, driveResumeSignal, engineReset;
   logic        pingpongBankClear, fifoFull, irq;
   int          n_mismatch = 0, total_checks = 0;
   always #5 mclk = ~mclk;
   usc_status_control u_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tokenDone(tokenDone), .tokenEndpoint(tokenEndpoint), .tokenIsIn(tokenIsIn), .tokenOdd(tokenOdd),
      .setupSeen(setupSeen), .tokenValid(tokenValid), .tokenAddress(tokenAddress), .sofSeen(sofSeen),
      .sofFrame(sofFrame), .busResetSeen(busResetSeen), .addressMatch(addressMatch),
      .moduleEnable(moduleEnable), .transactionSuspend(transactionSuspend),
      .driveResumeSignal(driveResumeSignal), .engineReset(engineReset),
      .pingpongBankClear(pingpongBankClear), .fifoFull(fifoFull), .irq(irq));
   usc_host_model u_host (.mclk(mclk), .tokenDone(tokenDone), .tokenEndpoint(tokenEndpoint),
      .tokenIsIn(tokenIsIn), .tokenOdd(tokenOdd), .setupSeen(setupSeen), .tokenValid(tokenValid),
      .tokenAddress(tokenAddress), .sofSeen(sofSeen), .sofFrame(sofFrame), .busResetSeen(busResetSeen));
   task report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      @(negedge mclk);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(rd, e)
   endtask
   task t_reset();
      rdchk(`USC_OFS_CONTROL, 32'h0000_0000);
      rdchk(`USC_OFS_ADDRESS, 32'h0000_0000);
      rdchk(`USC_OFS_FRM_HIGH, 32'h0000_0000);
      apb(1'b0, 12'h01C, 32'h0000_0000);
      `CHK(err, 1'b1)
      wr(`USC_OFS_EVT_MASK, 32'h0000_0001);
      $display("t_reset done");
   endtask
   // Five entries fit (the shown one plus four queued); any more are dropped.
   task t_fifo(input int first, input int n);
      int i;
      logic [7:0] e;
      for (i = 0; i < n; i++) u_host.send(2'd0, {5'h00, 4'(first + i), 1'(first + i), 1'((first + i) >> 1)});
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      `CHK(fifoFull, n > 4)
      for (i = 0; i < ((n > 5) ? 5 : n); i++) begin
         e = {4'(first + i), 1'(first + i), 1'((first + i) >> 1), 2'b00};
         `CHK(irq, 1'b1)
         rdchk(`USC_OFS_STATUS, {24'h00_0000, e});
         wr(`USC_OFS_EVT_STAT, 32'h0000_0001);
      end
      `CHK(irq, 1'b0)
      $display("t_fifo done");
   endtask
   task t_ctl();
      wr(`USC_OFS_CONTROL, 32'h0000_0001);
      `CHK({moduleEnable, engineReset, pingpongBankClear}, 3'b111)
      wr(`USC_OFS_CONTROL, 32'h0000_0007);
      `CHK({driveResumeSignal, engineReset, pingpongBankClear}, 3'b101)
      rdchk(`USC_OFS_CONTROL, 32'h0000_0005);
      wr(`USC_OFS_CONTROL, 32'h0000_0001);
      `CHK(driveResumeSignal, 1'b0)
      u_host.send(2'd1, 11'h000);
      @(negedge mclk);
      `CHK({transactionSuspend, irq}, 2'b10)
      wr(`USC_OFS_EVT_MASK, 32'h0000_0009);
      `CHK(irq, 1'b1)
      wr(`USC_OFS_EVT_STAT, 32'h0000_0008);
      `CHK(irq, 1'b0)
      rdchk(`USC_OFS_CONTROL, 32'h0000_0021);
      wr(`USC_OFS_CONTROL, 32'h0000_0001);
      `CHK(transactionSuspend, 1'b0)
      $display("t_ctl done");
   endtask
   task t_addr();
      wr(`USC_OFS_ADDRESS, 32'h0000_00FF);
      rdchk(`USC_OFS_ADDRESS, 32'h0000_007F);
      u_host.present(7'h7F);
      @(negedge mclk);
      `CHK(addressMatch, 1'b1)
      u_host.present(7'h00);
      @(negedge mclk);
      `CHK(addressMatch, 1'b0)
      u_host.send(2'd3, 11'h000);
      @(negedge mclk);
      `CHK(addressMatch, 1'b1)
      rdchk(`USC_OFS_ADDRESS, 32'h0000_0000);
      rdchk(`USC_OFS_EVT_STAT, 32'h0000_0002);
      wr(`USC_OFS_EVT_STAT, 32'h0000_0002);
      $display("t_addr done");
   endtask
   task t_frame(input logic [10:0] f);
      u_host.send(2'd2, f);
      rdchk(`USC_OFS_FRM_LOW, {24'h00_0000, f[7:0]});
      rdchk(`USC_OFS_FRM_HIGH, {29'h0000_0000, f[10:8]});
      rdchk(`USC_OFS_EVT_STAT, 32'h0000_0004);
      wr(`USC_OFS_EVT_STAT, 32'h0000_0004);
      $display("t_frame done");
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_fifo(0, 6);
      t_fifo(5, 2);
      t_ctl();
      t_addr();
      t_frame(11'h5A3);
      t_frame(11'h7FF);
      report_and_stop();
   end
endmodule // test_usc_status_control

// ===== tb/usc_host_model.sv
`timescale 1ns/100ps
module usc_host_model (
   input  wire logic        mclk,
   output logic             tokenDone,
   output logic [3:0]       tokenEndpoint,
   output logic             tokenIsIn,
   output logic             tokenOdd,
   output logic             setupSeen,
   output logic             tokenValid,
   output logic [6:0]       tokenAddress,
   output logic             sofSeen,
   output logic [10:0]      sofFrame,
   output logic             busResetSeen
);
   initial begin
      {tokenDone, setupSeen, sofSeen, busResetSeen, tokenValid} = 5'h00;
      {tokenEndpoint, tokenIsIn, tokenOdd, tokenAddress, sofFrame} = 24'h00_0000;
   end
   // Kinds: 0 completed transaction, 1 setup token, 2 frame start, 3 bus reset.
   task send(input logic [1:0] k, input logic [10:0] v);
      @(posedge mclk);
      tokenDone <= k == 2'd0;
      setupSeen <= k == 2'd1;
      sofSeen <= k == 2'd2;
      busResetSeen <= k == 2'd3;
      {tokenEndpoint, tokenIsIn, tokenOdd} <= v[5:0];
      sofFrame <= v;
      @(posedge mclk);
      {tokenDone, setupSeen, sofSeen, busResetSeen} <= 4'h0;
      // Released fields show the inverse, so a late capture cannot pass by luck.
      {tokenEndpoint, tokenIsIn, tokenOdd} <= ~v[5:0];
      sofFrame <= ~v;
   endtask
   task present(input logic [6:0] a);
      @(posedge mclk);
      tokenValid <= 1'b1;
      tokenAddress <= a;
   endtask
endmodule // usc_host_model

// ===== tb/usc_sc_assertions.sv
`timescale 1ns/100ps
`include "usc_defs.svh"
module usc_sc_assertions (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        setupSeen,
   input wire logic        tokenValid,
   input wire logic [6:0]  tokenAddress,
   input wire logic        sofSeen,
   input wire logic [10:0] sofFrame,
   input wire logic        busResetSeen,
   input wire logic        addressMatch,
   input wire logic        moduleEnable,
   input wire logic        transactionSuspend,
   input wire logic        engineReset,
   input wire logic        pingpongBankClear
);
   logic [10:0] lastFrm_ff;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // The checker keeps its own copy of the frame so reads compare against the capture, not the live input.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) lastFrm_ff <= 11'h000;
      else if (sofSeen) lastFrm_ff <= sofFrame;
   end
   sequence ctlWr;
      psel && penable && pwrite && paddr == `USC_OFS_CONTROL;
   endsequence
   sequence rdAt(logic [11:0] a);
      psel && penable && !pwrite && paddr == a;
   endsequence
   a_setup_sets_suspend: assert property (setupSeen |=> transactionSuspend)
      else $error("suspend flag not set after setup token");
   a_ctl_enable_write: assert property (ctlWr |=> moduleEnable == $past(pwdata[0]))
      else $error("enable does not follow control write");
   a_bank_clear_pulse: assert property (ctlWr ##0 pwdata[1] |=> pingpongBankClear)
      else $error("bank clear pulse missing");
   a_engine_reset_pair: assert property (engineReset |-> moduleEnable && pingpongBankClear)
      else $error("engine reset without enable and bank clear");
   a_match_needs_enable: assert property (addressMatch |-> tokenValid && moduleEnable)
      else $error("address match while idle or disabled");
   a_bus_reset_addr: assert property (busResetSeen ##1 (tokenValid && moduleEnable && tokenAddress == 7'h00)
      |-> addressMatch)
      else $error("default address not decoded after bus reset");
   a_addr_top_zero: assert property (rdAt(`USC_OFS_ADDRESS) |-> prdata[31:7] == 25'h000_0000)
      else $error("address bit 7 reads nonzero");
   a_frame_low_read: assert property (rdAt(`USC_OFS_FRM_LOW) |-> prdata == {24'h00_0000, lastFrm_ff[7:0]})
      else $error("frame low byte wrong");
   a_frame_high_read: assert property (rdAt(`USC_OFS_FRM_HIGH)
      |-> prdata == {29'h0000_0000, lastFrm_ff[10:8]})
      else $error("frame high bits wrong");
endmodule // usc_sc_assertions
bind usc_status_control usc_sc_assertions u_chk (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .setupSeen(setupSeen),
   .tokenValid(tokenValid), .tokenAddress(tokenAddress), .sofSeen(sofSeen), .sofFrame(sofFrame),
   .busResetSeen(busResetSeen), .addressMatch(addressMatch), .moduleEnable(moduleEnable),
   .transactionSuspend(transactionSuspend), .engineReset(engineReset), .pingpongBankClear(pingpongBankClear));

// ===== verilog/usc_defs.svh
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define USC_OFS_STATUS    12'h000
`define USC_OFS_CONTROL   12'h004
`define USC_OFS_ADDRESS   12'h008
`define USC_OFS_FRM_LOW   12'h00C
`define USC_OFS_FRM_HIGH  12'h010
`define USC_OFS_EVT_STAT  12'h014
`define USC_OFS_EVT_MASK  12'h018

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define USC_CTL_SUSPEND   5
`define USC_CTL_RESUME    2
`define USC_CTL_BANKCLR   1
`define USC_CTL_ENABLE    0
`define USC_EVT_TOKDONE   0
`define USC_EVT_BUSRESET  1
`define USC_EVT_SOF       2
`define USC_EVT_SETUP     3

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define USC_CTL_RESET     8'h00
`define USC_ADDR_RESET    7'h00
`define USC_STAT_RESET    8'h00
`define USC_FRML_RESET    8'h00
`define USC_FRMH_RESET    3'h0
`define USC_FIFO_DEPTH    4
`define USC_NUM_EVENTS    4

`endif

// ===== verilog/usc_pkg.sv
package usc_pkg;
   typedef enum logic [1:0] {
      USC_DIR_OUT,
      USC_DIR_IN,
      USC_DIR_SETUP
   } usc_dir_t;
   typedef logic [7:0] usc_status_t;
endpackage

// ===== verilog/usc_status_control.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "usc_defs.svh"

// Notes on behaviour
// - Status register holds meaningful data only while token-done flag is set.
// - Each completed transaction with a used descriptor produces a status entry unless four entries already wait.
// - Status entries queue in order in a four-entry byte FIFO.
// - Clearing token-done loads the next queued entry into the status register.
// - If a further entry is waiting, token-done is raised again immediately.
// - Status bits 7..4 give the endpoint number of the last token.
// - Status bit 3 is one for IN transfers, zero for OUT.
// - Status bit 2 is one when the descriptor was in the odd bank.
// - A SETUP token sets control bit 5 and halts packet traffic.
// - Software clears control bit 5; token processing then resumes.
// - Control bit 2 drives resume signalling; software times and clears it.
// - Writing one to control bit 1 clears the odd bits of all endpoints.
// - Control bit 0 enables the module; setting it clears odd bits and engine.
// - Seven-bit address in bits 6..0 filters tokens; bit 7 reads zero.
// - Address clears to zero on reset and on USB bus reset.
// - Each SOF captures the 11-bit frame number into two registers.
module usc_status_control (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tokenDone,
   input  wire logic [3:0]  tokenEndpoint,
   input  wire logic        tokenIsIn,
   input  wire logic        tokenOdd,
   input  wire logic        setupSeen,
   input  wire logic        tokenValid,
   input  wire logic [6:0]  tokenAddress,
   input  wire logic        sofSeen,
   input  wire logic [10:0] sofFrame,
   input  wire logic        busResetSeen,
   output logic             addressMatch,
   output logic             moduleEnable,
   output logic             transactionSuspend,
   output logic             driveResumeSignal,
   output logic             engineReset,
   output logic             pingpongBankClear,
   output logic             fifoFull,
   output logic             irq
);

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   logic wrAcc;
   logic rdAcc;
   logic hitStatus;
   logic hitControl;
   logic hitAddress;
   logic hitFrmLow;
   logic hitFrmHigh;
   logic hitEvtStat;
   logic hitEvtMask;
   logic hitAny;

   always_comb begin
      hitStatus  = 1'b0;
      hitControl = 1'b0;
      hitAddress = 1'b0;
      hitFrmLow  = 1'b0;
      hitFrmHigh = 1'b0;
      hitEvtStat = 1'b0;
      hitEvtMask = 1'b0;
      if (paddr == `USC_OFS_STATUS) begin
         hitStatus = 1'b1;
      end else if (paddr == `USC_OFS_CONTROL) begin
         hitControl = 1'b1;
      end else if (paddr == `USC_OFS_ADDRESS) begin
         hitAddress = 1'b1;
      end else if (paddr == `USC_OFS_FRM_LOW) begin
         hitFrmLow = 1'b1;
      end else if (paddr == `USC_OFS_FRM_HIGH) begin
         hitFrmHigh = 1'b1;
      end else if (paddr == `USC_OFS_EVT_STAT) begin
         hitEvtStat = 1'b1;
      end else if (paddr == `USC_OFS_EVT_MASK) begin
         hitEvtMask = 1'b1;
      end
   end

   assign hitAny  = hitStatus | hitControl | hitAddress | hitFrmLow | hitFrmHigh | hitEvtStat | hitEvtMask;
   // Every register answers in the access cycle, so the bus never waits.
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hitAny;
   assign wrAcc   = psel & penable & pwrite & hitAny;
   assign rdAcc   = psel & penable & ~pwrite & hitAny;

   // -------------------------------------------------------------------------
   // Status FIFO
   // -------------------------------------------------------------------------
   // The status register is the head of the queue. A head entry is only
   // presented while token-done is set, so the queue plus head is the store.
   usc_pkg::usc_status_t fifoMem_ff [`USC_FIFO_DEPTH];
   logic [1:0]           rdPtr_ff;
   logic [1:0]           wrPtr_ff;
   logic [2:0]           count_ff;
   usc_pkg::usc_status_t status_ff;
   logic                 tokDoneFlag_ff;
   usc_pkg::usc_status_t newEntry;
   logic                 push;
   logic                 pop;
   logic                 clearTokDone;

   assign newEntry     = {tokenEndpoint, tokenIsIn, tokenOdd, 2'b00};
   assign fifoFull     = (count_ff == 3'(`USC_FIFO_DEPTH));
   // A completion that arrives while four entries wait is lost; software must
   // service token-done before the engine finishes five more transactions.
   assign push         = tokenDone & ~fifoFull;
   assign clearTokDone = wrAcc & hitEvtStat & pwdata[`USC_EVT_TOKDONE];
   assign pop          = (count_ff != 3'd0) & (~tokDoneFlag_ff | clearTokDone);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wrPtr_ff <= 2'd0;
      end else if (push) begin
         wrPtr_ff <= wrPtr_ff + 2'd1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdPtr_ff <= 2'd0;
      end else if (pop) begin
         rdPtr_ff <= rdPtr_ff + 2'd1;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         count_ff <= 3'd0;
      end else begin
         count_ff <= count_ff + 3'(push) - 3'(pop);
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         fifoMem_ff[wrPtr_ff] <= newEntry;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         status_ff <= `USC_STAT_RESET;
      end else if (pop) begin
         status_ff <= fifoMem_ff[rdPtr_ff];
      end
   end

   // Token-done reasserts at once when another entry is waiting.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tokDoneFlag_ff <= 1'b0;
      end else if (pop) begin
         tokDoneFlag_ff <= 1'b1;
      end else if (clearTokDone) begin
         tokDoneFlag_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------------------
   logic suspend_ff;
   logic resume_ff;
   logic enable_ff;
   logic bankClr_ff;
   logic engRst_ff;
   logic ctlWrite;
   logic enableRise;
   logic bankClrReq;

   assign ctlWrite   = wrAcc & hitControl;
   // Only a zero-to-one step of enable restarts the engine; rewriting a one keeps traffic going.
   assign enableRise = ctlWrite & pwdata[`USC_CTL_ENABLE] & ~enable_ff;
   assign bankClrReq = (ctlWrite & pwdata[`USC_CTL_BANKCLR]) | enableRise;

   // A setup token beats a software clear in the same cycle, so it is never lost.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         suspend_ff <= 1'b0;
      end else if (setupSeen) begin
         suspend_ff <= 1'b1;
      end else if (ctlWrite) begin
         suspend_ff <= pwdata[`USC_CTL_SUSPEND];
      end
   end

   // Resume signalling is not timed here; software owns its length.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         resume_ff <= 1'b0;
      end else if (ctlWrite) begin
         resume_ff <= pwdata[`USC_CTL_RESUME];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         enable_ff <= 1'b0;
      end else if (ctlWrite) begin
         enable_ff <= pwdata[`USC_CTL_ENABLE];
      end
   end

   // Bank clear and engine reset are one-cycle pulses; bit 1 never stores.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         bankClr_ff <= 1'b0;
      end else begin
         bankClr_ff <= bankClrReq;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         engRst_ff <= 1'b0;
      end else begin
         engRst_ff <= enableRise;
      end
   end

   assign moduleEnable       = enable_ff;
   assign transactionSuspend = suspend_ff;
   assign driveResumeSignal  = resume_ff;
   assign pingpongBankClear  = bankClr_ff;
   assign engineReset        = engRst_ff;

   // -------------------------------------------------------------------------
   // Address and frame number
   // -------------------------------------------------------------------------
   logic [6:0]  devAddr_ff;
   logic [7:0]  frmLow_ff;
   logic [2:0]  frmHigh_ff;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         devAddr_ff <= `USC_ADDR_RESET;
      end else if (busResetSeen) begin
         devAddr_ff <= `USC_ADDR_RESET;
      end else if (wrAcc & hitAddress) begin
         devAddr_ff <= pwdata[6:0];
      end
   end

   // A disabled module matches nothing, not even the default address.
   assign addressMatch = tokenValid & enable_ff & (tokenAddress == devAddr_ff);

   // Both halves load on the same edge, so a read never mixes two frames.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         frmLow_ff <= `USC_FRML_RESET;
      end else if (sofSeen) begin
         frmLow_ff <= sofFrame[7:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         frmHigh_ff <= `USC_FRMH_RESET;
      end else if (sofSeen) begin
         frmHigh_ff <= sofFrame[10:8];
      end
   end

   // -------------------------------------------------------------------------
   // Event status and mask
   // -------------------------------------------------------------------------
   logic [`USC_NUM_EVENTS-1:0] evtStat_ff;
   logic [`USC_NUM_EVENTS-1:0] evtMask_ff;
   logic [`USC_NUM_EVENTS-1:0] evtSet;
   logic [`USC_NUM_EVENTS-1:0] evtClr;

   // Token-done lives in its own flag so that popping can re-raise it.
   always_comb begin
      evtSet                    = '0;
      evtSet[`USC_EVT_BUSRESET] = busResetSeen;
      evtSet[`USC_EVT_SOF]      = sofSeen;
      evtSet[`USC_EVT_SETUP]    = setupSeen;
   end

   always_comb begin
      evtClr = '0;
      if (wrAcc & hitEvtStat) begin
         evtClr = pwdata[`USC_NUM_EVENTS-1:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         evtStat_ff <= '0;
      end else begin
         // Set wins over a write-one-to-clear in the same cycle.
         evtStat_ff <= (evtStat_ff & ~evtClr) | evtSet;
      end
   end

   // The mask only gates the interrupt line; status bits still record events.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         evtMask_ff <= '0;
      end else if (wrAcc & hitEvtMask) begin
         evtMask_ff <= pwdata[`USC_NUM_EVENTS-1:0];
      end
   end

   logic [`USC_NUM_EVENTS-1:0] evtView;

   always_comb begin
      evtView                   = evtStat_ff;
      evtView[`USC_EVT_TOKDONE] = tokDoneFlag_ff;
   end
   assign irq     = |(evtView & evtMask_ff);

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   // Idle and unmapped cycles read zero, so no stale value leaks onto the bus.
   always_comb begin
      prdata = 32'h0000_0000;
      if (rdAcc & hitStatus) begin
         prdata[7:0] = status_ff;
      end else if (rdAcc & hitControl) begin
         prdata[`USC_CTL_SUSPEND] = suspend_ff;
         prdata[`USC_CTL_RESUME]  = resume_ff;
         prdata[`USC_CTL_ENABLE]  = enable_ff;
      end else if (rdAcc & hitAddress) begin
         prdata[6:0] = devAddr_ff;
      end else if (rdAcc & hitFrmLow) begin
         prdata[7:0] = frmLow_ff;
      end else if (rdAcc & hitFrmHigh) begin
         prdata[2:0] = frmHigh_ff;
      end else if (rdAcc & hitEvtStat) begin
         prdata[`USC_NUM_EVENTS-1:0] = evtView;
      end else if (rdAcc & hitEvtMask) begin
         prdata[`USC_NUM_EVENTS-1:0] = evtMask_ff;
      end
   end

endmodule // usc_status_control
